// *** core/synth_pins.sv ***
// Pin-level control and status logic of the synthesizer with an AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "synth_pins_defs.svh"
module synth_pins
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire logic master_reset_in,
   input wire logic power_down_request_in,
   input wire logic [2:0] profile_select_in,
   input wire logic update_in,
   input wire logic [1:0] format_in,
   input wire logic [15:0] word_bus_in,
   input wire logic word_valid_in,
   input wire logic align_sync_in,
   input wire logic pll_locked_in,
   input wire logic sweep_finished_in,
   output logic pll_lock_out,
   output logic table_sweep_done_out,
   output logic align_sample_error_out,
   output logic word_strobe_clock_out,
   output logic align_sync_out,
   output logic sync_clock_out,
   output logic power_down_out,
   output logic [1:0] power_down_mode_out,
   output logic [2:0] active_profile_out,
   output logic [31:0] active_word_out,
   output logic active_load_out,
   output logic [15:0] word_data_out,
   output logic [1:0] word_format_out,
   output logic word_data_valid_out
);

   localparam logic [7:0] SYNC_TIMEOUT = 8'(`SYNC_TIMEOUT_CYC);

   synth_pins_pkg::state_t st;
   synth_pins_pkg::state_t next_st;
   synth_pins_pkg::pin_in_t pins;
   logic sclk_rise;
   logic addr_ok;

   function automatic logic rose(input logic prev, input logic cur);
      rose = cur & ~prev;
   endfunction : rose

   function automatic synth_pins_pkg::state_t reset_state();
      synth_pins_pkg::state_t r;
      r = '0;
      r.pd_mode = `RST_PD_MODE;
      r.buf_word = `RST_BUF_WORD;
      r.irq_mask = `RST_IRQ_MASK;
      reset_state = r;
   endfunction : reset_state

   // ************************************************************
   // Pins and subclocks
   // ************************************************************
   always_comb
   begin
      pins.pd = power_down_request_in;
      pins.prof = profile_select_in;
      pins.upd = update_in;
      pins.fmt = format_in;
      pins.valid = word_valid_in;
      pins.sync_in = align_sync_in;
      pins.lock = pll_locked_in;
      pins.word = word_bus_in;
   end

   // Sampling strobe fires as the divider passes from 1 to 2, one edge before the sync clock output rises
   assign sclk_rise = (st.div == 2'h1);
   assign addr_ok = hsel & htrans[1] & hready & (haddr[1:0] == 2'h0) & (haddr[31:5] == '0);

   always_comb
   begin
      logic [3:0] events;
      logic [31:0] rd;
      next_st = st;
      events = '0;
      rd = '0;
      next_st.p1 = pins;
      next_st.p2 = st.p1;
      next_st.m1 = master_reset_in;
      next_st.m2 = st.m1;
      next_st.load = 1'b0;
      next_st.word_seen = 1'b0;
      next_st.div = st.div + 2'h1;
      next_st.sync_prev = st.p2.sync_in;
      // Master sync edge pulls the divider back to phase zero
      if (rose(st.sync_prev, st.p2.sync_in))
      begin
         next_st.div = 2'h0;
      end
      next_st.sclk = st.div[1];
      next_st.sync_out = (st.div == 2'h3);
      // Sync watchdog: error while no master edge inside the timeout
      if (rose(st.sync_prev, st.p2.sync_in))
      begin
         next_st.watchdog = '0;
         next_st.sync_err = 1'b0;
      end
      else if (st.watchdog >= SYNC_TIMEOUT)
      begin
         next_st.sync_err = 1'b1;
      end
      else
      begin
         next_st.watchdog = st.watchdog + 8'h1;
      end
      next_st.lock = st.p2.lock;
      next_st.sweep = sweep_finished_in;
      next_st.pd_active = st.p2.pd;
      // ************************************************************
      // Update and profile sampling on the sync clock edge
      // ************************************************************
      if (sclk_rise)
      begin
         next_st.prof_q = st.p2.prof;
         next_st.upd_q = st.p2.upd;
         if (st.p2.upd || (st.p2.prof != st.prof_q))
         begin
            next_st.active_word = st.buf_word;
            next_st.load = 1'b1;
         end
         // Words are taken one edge before the strobe rises, only while marked valid
         if (st.p2.valid)
         begin
            next_st.last_word = st.p2.word;
            next_st.last_fmt = st.p2.fmt;
            next_st.word_seen = 1'b1;
         end
      end
      events[`IRQ_LOAD] = next_st.load;
      events[`IRQ_SWEEP] = rose(st.sweep, next_st.sweep);
      events[`IRQ_SYNC_ERR] = rose(st.sync_err, next_st.sync_err);
      events[`IRQ_LOCK_LOST] = st.lock & ~next_st.lock;
      // ************************************************************
      // Bus data phase: writes land here, reads were captured earlier
      // ************************************************************
      if (st.bus.wr)
      begin
         case (st.bus.addr)
            `OFF_CTRL: next_st.pd_mode = hwdata[1:0];
            `OFF_BUF_WORD: next_st.buf_word = hwdata;
            `OFF_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~hwdata[`IRQ_W-1:0];
            `OFF_IRQ_MASK: next_st.irq_mask = hwdata[`IRQ_W-1:0];
            default: next_st.pd_mode = next_st.pd_mode;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_st.irq_stat = next_st.irq_stat | events;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      next_st.bus.wr = addr_ok & hwrite;
      next_st.bus.addr = haddr[4:0];
      case (haddr[4:0])
         `OFF_CTRL: rd = {30'h0, st.pd_mode};
         `OFF_BUF_WORD: rd = st.buf_word;
         `OFF_ACTIVE_WORD: rd = st.active_word;
         `OFF_STATUS: rd = {22'h0, st.last_fmt, st.prof_q, st.pd_active, st.sweep,
                            st.sync_err, st.lock, st.upd_q};
         `OFF_IRQ_STAT: rd = {28'h0, st.irq_stat};
         `OFF_IRQ_MASK: rd = {28'h0, st.irq_mask};
         `OFF_LAST_WORD: rd = {16'h0, st.last_word};
         default: rd = '0;
      endcase
      next_st.bus.rdata = (addr_ok & ~hwrite) ? rd : '0;
      // Master reset pin clears everything except its own synchroniser and the pin synchronisers
      if (st.m2)
      begin
         next_st = reset_state();
         next_st.m1 = master_reset_in;
         next_st.m2 = st.m1;
         next_st.p1 = pins;
         next_st.p2 = st.p1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign hrdata = st.bus.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = st.irq;
   assign pll_lock_out = st.lock;
   assign table_sweep_done_out = st.sweep;
   assign align_sample_error_out = st.sync_err;
   assign sync_clock_out = st.sclk;
   assign word_strobe_clock_out = st.sclk;
   assign align_sync_out = st.sync_out;
   assign power_down_out = st.pd_active;
   assign power_down_mode_out = st.pd_mode;
   assign active_profile_out = st.prof_q;
   assign active_word_out = st.active_word;
   assign active_load_out = st.load;
   assign word_data_out = st.last_word;
   assign word_format_out = st.last_fmt;
   assign word_data_valid_out = st.word_seen;

   // ************************************************************
   // Checks
   // ************************************************************
   a_master_reset_clear: assert property (@(posedge mclk) disable iff (!rst_b)
      st.m2 |=> (st.active_word == '0 && st.irq_stat == '0 && st.buf_word == '0))
      else $error("master reset left state behind");

   a_pd_follows_pin: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      st.p2.pd |=> power_down_out)
      else $error("power down not entered");

   a_lock_follows: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (st.p2.lock != st.lock) |=> (pll_lock_out == $past(st.p2.lock)))
      else $error("lock output lags");

   a_sync_err_timeout: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (st.watchdog == SYNC_TIMEOUT && !rose(st.sync_prev, st.p2.sync_in))
      |=> align_sample_error_out)
      else $error("sync error not raised");

   a_profile_load: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (sclk_rise && st.p2.prof != st.prof_q) |=> (active_load_out && active_profile_out ==
      $past(st.p2.prof) && active_word_out == $past(st.buf_word)))
      else $error("profile change did not load");

   a_update_load: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (sclk_rise && st.p2.upd) |=> active_load_out)
      else $error("update did not load");

   a_sclk_quarter: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      ($rose(sync_clock_out) && !$past(rose(st.sync_prev, st.p2.sync_in)))
      |-> ##1 sync_clock_out ##1 !sync_clock_out ##1 !sync_clock_out)
      else $error("sync clock not divide by four");

   a_sync_realign: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      rose(st.sync_prev, st.p2.sync_in) |=> (st.div == 2'h0))
      else $error("subclocks not realigned");

   a_word_capture: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (sclk_rise && st.p2.valid) |=> (word_data_valid_out && word_data_out ==
      $past(st.p2.word) && word_format_out == $past(st.p2.fmt)))
      else $error("word not captured");

   a_no_word_idle: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      !(sclk_rise && st.p2.valid) |=> !word_data_valid_out)
      else $error("word taken without valid");

   a_sync_out_phase: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      $rose(align_sync_out) |=> !align_sync_out ##1 !align_sync_out ##1 !align_sync_out)
      else $error("sync out too wide");

   // ************************************************************
   // Hold, clear, sampling and phase checks
   // ************************************************************
   a_sweep_level: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      1'b1 |=> (table_sweep_done_out == $past(sweep_finished_in)))
      else $error("sweep done output not registered");

   a_lock_steady: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (st.p2.lock == st.lock) |=> $stable(pll_lock_out))
      else $error("lock output glitched");

   a_profile_take: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      sclk_rise |=> (active_profile_out == $past(st.p2.prof)))
      else $error("profile not sampled at sync clock edge");

   a_profile_steady: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      !sclk_rise |=> $stable(active_profile_out))
      else $error("profile moved between sync clock edges");

   a_word_steady: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      !(sclk_rise && st.p2.valid) |=> ($stable(word_data_out) && $stable(word_format_out)))
      else $error("word or format moved without capture");

   a_active_steady: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      !(sclk_rise && (st.p2.upd || st.p2.prof != st.prof_q))
      |=> ($stable(active_word_out) && !active_load_out))
      else $error("active word loaded without cause");

   a_sync_err_clear: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      rose(st.sync_prev, st.p2.sync_in) |=> !align_sample_error_out)
      else $error("sync error not cleared by sync edge");

   a_sync_err_quiet: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (st.watchdog < SYNC_TIMEOUT && !st.sync_err) |=> !align_sample_error_out)
      else $error("sync error raised early");

   a_pd_release: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      !st.p2.pd |=> !power_down_out)
      else $error("power down held without request");

   a_sclk_phase: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      1'b1 |=> (sync_clock_out == $past(st.div[1])))
      else $error("sync clock off divider phase");

   a_sync_out_div: assert property (@(posedge mclk) disable iff (!rst_b || st.m2)
      (st.div == 2'h3) |=> align_sync_out)
      else $error("sync out pulse missing");

   a_reset_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      st.m2 |=> (!active_load_out && !word_data_valid_out && !irq && !align_sync_out))
      else $error("outputs active during master reset");

endmodule : synth_pins

// *** common/synth_pins_defs.svh ***
// Constants for the synthesizer control pin block: offsets, reset values, timing
`ifndef SYNTH_PINS_DEFS_SVH
`define SYNTH_PINS_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFF_CTRL 5'h00
`define OFF_BUF_WORD 5'h04
`define OFF_ACTIVE_WORD 5'h08
`define OFF_STATUS 5'h0c
`define OFF_IRQ_STAT 5'h10
`define OFF_IRQ_MASK 5'h14
`define OFF_LAST_WORD 5'h18

// ************************************************************
// Reset values and field positions
// ************************************************************
`define RST_PD_MODE 2'h0
`define RST_BUF_WORD 32'h0000_0000
`define RST_IRQ_MASK 4'h0
`define IRQ_LOAD 0
`define IRQ_SWEEP 1
`define IRQ_SYNC_ERR 2
`define IRQ_LOCK_LOST 3
`define IRQ_W 4

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 100
`define SYNC_TIMEOUT_NS 2000
`define SYNC_TIMEOUT_CYC ((`SYNC_TIMEOUT_NS) / (`CLK_PERIOD_NS))
`define SUBCLK_DIV 4

`endif

// *** common/synth_pins_pkg.sv ***
// Types for the synthesizer control pin block
package synth_pins_pkg;

   // Pins that arrive from outside the clock domain
   typedef struct packed {
      logic pd;
      logic [2:0] prof;
      logic upd;
      logic [1:0] fmt;
      logic valid;
      logic sync_in;
      logic lock;
      logic [15:0] word;
   } pin_in_t;

   // Bus data phase bookkeeping
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [31:0] rdata;
   } bus_phase_t;

   typedef struct packed {
      logic m1;
      logic m2;
      pin_in_t p1;
      pin_in_t p2;
      logic [1:0] div;
      logic sync_prev;
      logic [2:0] prof_q;
      logic upd_q;
      logic [7:0] watchdog;
      logic sync_err;
      logic lock;
      logic sweep;
      logic [1:0] pd_mode;
      logic pd_active;
      logic [31:0] buf_word;
      logic [31:0] active_word;
      logic [15:0] last_word;
      logic [1:0] last_fmt;
      logic word_seen;
      logic load;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic sclk;
      logic sync_out;
      bus_phase_t bus;
   } state_t;

endpackage : synth_pins_pkg

// *** dv/synth_ctl_model.sv ***
// Behavioural model of the external controller that drives the control pins
`timescale 1ns/10ps
module synth_ctl_model
(
   input wire logic mclk,
   input wire logic sync_run,
   output logic [2:0] profile_select_in,
   output logic update_in,
   output logic [1:0] format_in,
   output logic [15:0] word_bus_in,
   output logic word_valid_in,
   output logic align_sync_in
);
   // ************************************************************
   // Master sync, 800 ns period, held low while stopped
   // ************************************************************
   initial
   begin
      profile_select_in = 3'h0;
      update_in = 1'b0;
      format_in = 2'h0;
      word_bus_in = 16'h0;
      word_valid_in = 1'b0;
      align_sync_in = 1'b0;
      forever
      begin
         #400;
         align_sync_in = sync_run ? ~align_sync_in : 1'b0;
      end
   end

   // Pins move just after a core edge; callers hold them past a sync clock rise
   task set_ctl(input logic [2:0] p, input logic u);
      @(posedge mclk);
      profile_select_in <= p;
      update_in <= u;
   endtask : set_ctl

   // A released bus shows the inverse so a stale word is never mistaken for data
   task set_word(input logic [1:0] f, input logic [15:0] w, input logic v);
      @(posedge mclk);
      format_in <= f;
      word_bus_in <= v ? w : ~w;
      word_valid_in <= v;
   endtask : set_word
endmodule : synth_ctl_model

// *** dv/synth_control_pin_interface_tb_top.sv ***
// Self-checking testbench of the synthesizer control pin block
`timescale 1ns/10ps
`include "synth_pins_defs.svh"
module synth_control_pin_interface_tb_top;
   logic mclk, rst_b, hsel, hwrite, master_reset_in, power_down_request_in, sp;
   logic pll_locked_in, sweep_finished_in, sync_run;
   logic [31:0] haddr, hwdata, hrdata, active_word_out, rd, bw;
   logic [1:0] htrans, power_down_mode_out, word_format_out, format_in, m;
   logic [2:0] hsize, profile_select_in, active_profile_out;
   logic [15:0] word_bus_in, word_data_out, w;
   wire hreadyout, hresp, irq, update_in, word_valid_in, align_sync_in, pll_lock_out;
   wire table_sweep_done_out, align_sample_error_out, word_strobe_clock_out;
   wire align_sync_out, sync_clock_out, power_down_out, active_load_out, word_data_valid_out;
   int fails, cmp_count, i, n0, n1, n2;

   synth_pins u_synth_pins (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .master_reset_in,
      .power_down_request_in, .profile_select_in, .update_in, .format_in, .word_bus_in,
      .word_valid_in, .align_sync_in, .pll_locked_in, .sweep_finished_in, .pll_lock_out,
      .table_sweep_done_out, .align_sample_error_out, .word_strobe_clock_out,
      .align_sync_out, .sync_clock_out, .power_down_out, .power_down_mode_out,
      .active_profile_out, .active_word_out, .active_load_out, .word_data_out,
      .word_format_out, .word_data_valid_out);
   synth_ctl_model u_synth_ctl_model (.mclk, .sync_run, .profile_select_in, .update_in,
      .format_in, .word_bus_in, .word_valid_in, .align_sync_in);

   // ************************************************************
   // Bench tasks
   // ************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task ahb(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {27'h0, a};
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : ahb

   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // ************************************************************
   // Clock, watchdog and tests
   // ************************************************************
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (6000) @(posedge mclk);
      fails++;
      print_verdict;
   end

   initial
   begin
      {rst_b, hsel, hwrite, master_reset_in, power_down_request_in} = 5'h0;
      {pll_locked_in, sweep_finished_in, haddr, hwdata, htrans} = 68'h0;
      hsize = 3'h2;
      sync_run = 1'b1;
      fails = 0;
      cmp_count = 0;
      void'($urandom(16));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      ahb(1'b0, `OFF_CTRL, 32'h0, rd);
      chk(rd, {30'h0, `RST_PD_MODE});
      ahb(1'b0, `OFF_IRQ_MASK, 32'h0, rd);
      chk(rd, {28'h0, `RST_IRQ_MASK});
      bw = $urandom;
      ahb(1'b1, 5'h1c, bw, rd);
      ahb(1'b0, 5'h1c, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, `OFF_BUF_WORD, bw, rd);
      $display("done: registers");
      for (int p = 1; p <= 8; p++)
      begin
         u_synth_ctl_model.set_ctl(p[2:0], 1'b0);
         for (i = 0; i < 40 && active_load_out !== 1'b1; i++) @(negedge mclk);
         chk(active_load_out, 32'h1);
         chk(active_profile_out, p[2:0]);
         chk(active_word_out, bw);
         repeat (12) @(posedge mclk);
      end
      ahb(1'b0, `OFF_ACTIVE_WORD, 32'h0, rd);
      chk(rd, bw);
      bw = $urandom;
      ahb(1'b1, `OFF_BUF_WORD, bw, rd);
      u_synth_ctl_model.set_ctl(3'h0, 1'b1);
      for (i = 0; i < 40 && active_load_out !== 1'b1; i++) @(negedge mclk);
      chk(active_load_out, 32'h1);
      chk(active_word_out, bw);
      u_synth_ctl_model.set_ctl(3'h0, 1'b0);
      $display("done: profiles and update");
      for (int f = 0; f < 4; f++)
      begin
         w = $urandom;
         u_synth_ctl_model.set_word(f[1:0], w, 1'b1);
         for (i = 0; i < 40 && word_data_valid_out !== 1'b1; i++) @(negedge mclk);
         chk(word_data_valid_out, 32'h1);
         chk(word_data_out, w);
         chk(word_format_out, f[1:0]);
         u_synth_ctl_model.set_word(f[1:0], w, 1'b0);
         repeat (12) @(posedge mclk);
      end
      ahb(1'b0, `OFF_LAST_WORD, 32'h0, rd);
      chk(rd, {16'h0, w});
      {n0, n1, n2} = 0;
      sp = sync_clock_out;
      for (i = 0; i < 40; i++)
      begin
         @(negedge mclk);
         n0 += (sync_clock_out === 1'b1 && sp === 1'b0);
         n1 += (align_sync_out === 1'b1);
         n2 += (word_strobe_clock_out === 1'b1);
         sp = sync_clock_out;
      end
      chk(n0, 32'ha);
      chk(n1, 32'ha);
      chk(n2, 32'h14);
      $display("done: words and clocks");
      m = $urandom;
      ahb(1'b1, `OFF_CTRL, {30'h0, m}, rd);
      @(posedge mclk);
      power_down_request_in <= 1'b1;
      pll_locked_in <= 1'b1;
      sweep_finished_in <= 1'b1;
      for (i = 0; i < 20 && power_down_out !== 1'b1; i++) @(negedge mclk);
      chk(power_down_out, 32'h1);
      chk(power_down_mode_out, m);
      chk(pll_lock_out, 32'h1);
      chk(table_sweep_done_out, 32'h1);
      @(posedge mclk);
      {power_down_request_in, pll_locked_in, sweep_finished_in} <= 3'h0;
      repeat (6) @(negedge mclk);
      chk({power_down_out, pll_lock_out, table_sweep_done_out}, 32'h0);
      @(posedge mclk);
      sync_run <= 1'b0;
      for (i = 0; i < 40 && align_sample_error_out !== 1'b1; i++) @(negedge mclk);
      chk(align_sample_error_out, 32'h1);
      chk(irq, 32'h0);
      // Load, sweep rise, sync error rise and lock loss have all happened by now
      ahb(1'b0, `OFF_IRQ_STAT, 32'h0, rd);
      chk(rd, {28'h0, 4'hf});
      ahb(1'b1, `OFF_IRQ_MASK, 32'h1 << `IRQ_SYNC_ERR, rd);
      repeat (3) @(negedge mclk);
      chk(irq, 32'h1);
      ahb(1'b1, `OFF_IRQ_STAT, 32'h1 << `IRQ_SYNC_ERR, rd);
      repeat (3) @(negedge mclk);
      chk(irq, 32'h0);
      sync_run <= 1'b1;
      for (i = 0; i < 40 && align_sample_error_out !== 1'b0; i++) @(negedge mclk);
      chk(align_sample_error_out, 32'h0);
      $display("done: status and interrupt");
      @(posedge mclk);
      master_reset_in <= 1'b1;
      repeat (6) @(posedge mclk);
      master_reset_in <= 1'b0;
      repeat (4) @(posedge mclk);
      ahb(1'b0, `OFF_BUF_WORD, 32'h0, rd);
      chk(rd, `RST_BUF_WORD);
      chk(active_word_out, 32'h0);
      $display("done: master reset");
      print_verdict;
   end
endmodule : synth_control_pin_interface_tb_top
